// ### design/cdr_pkg.sv
// Purpose: Shared constants and types for the coil driver mode and ringing control
// Assumes: 50 MHz core clock, register port driven by a serial slave engine on the same clock
// Notes: Register offsets are the byte numbers seen over the serial interface
package cdr_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = 50;
  localparam int SCL_TIMEOUT_US = 500;
  localparam int SCL_TIMEOUT_CYC = (SCL_TIMEOUT_US * CLK_MHZ * 1000 + 999) / 1000;
  localparam int RING_F_MIN_HZ = 50;
  localparam int RING_F_MAX_HZ = 150;
  localparam int RAMP_SEGS = 16;
  localparam int SEG_SLOW_CYC = CLK_HZ / (RING_F_MIN_HZ * RAMP_SEGS);
  localparam int SEG_FAST_CYC = CLK_HZ / (RING_F_MAX_HZ * RAMP_SEGS);
  localparam int PWM_F0_KHZ = 500;
  localparam int PWM_F1_KHZ = 1000;
  localparam int PWM_F2_KHZ = 2000;
  localparam int PWM_F3_KHZ = 4000;
  localparam logic [6:0] PWM_P0_CYC = 7'(CLK_HZ / (PWM_F0_KHZ * 1000));
  localparam logic [6:0] PWM_P1_CYC = 7'(CLK_HZ / (PWM_F1_KHZ * 1000));
  localparam logic [6:0] PWM_P2_CYC = 7'(CLK_HZ / (PWM_F2_KHZ * 1000));
  localparam logic [6:0] PWM_P3_CYC = 7'(CLK_HZ / (PWM_F3_KHZ * 1000));

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam logic [7:0] ADDR_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_SETPOINT_MSB = 8'h03;
  localparam logic [7:0] ADDR_SETPOINT_LSB = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_MODE = 8'h06;
  localparam logic [7:0] ADDR_RES_FREQ = 8'h07;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_RING_EN_BIT = 1;
  localparam int CTRL_PWM_FREQ_LSB = 2;
  localparam int MODE_PWM_BIT = 0;
  localparam int MODE_TWO_PERIOD_BIT = 1;
  localparam int STAT_OVERTEMP_BIT = 0;
  localparam int STAT_SHORT_BIT = 1;
  localparam int STAT_OPEN_BIT = 2;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic RING_EN_RST = 1'b1;
  localparam logic [1:0] PWM_FREQ_RST = 2'h0;
  localparam logic [9:0] SETPOINT_RST = 10'h000;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [7:0] RES_FREQ_RST = 8'h83;

  // Ramp shape weights, out of 256, one per segment
  localparam logic [15:0][8:0] RAMP_W = {
    9'h100, 9'h0fe, 9'h0f9, 9'h0f0, 9'h0e3, 9'h0d3, 9'h0bf, 9'h0a8,
    9'h090, 9'h078, 9'h060, 9'h049, 9'h034, 9'h022, 9'h012, 9'h005
  };

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CDR_SHUTDOWN = 2'b00,
    CDR_STANDBY = 2'b01,
    CDR_ACTIVE = 2'b10
  } cdr_pwr_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cdr_req_t;

  typedef struct packed {
    logic stage_en;
    logic pwm_sel;
    logic hs_on;
    logic ls_on;
    logic lin_src_en;
    logic [9:0] dac_code;
  } cdr_drive_t;

endpackage

// ### design/cdr_core.sv
// Purpose: Power modes, output drive selection and ringing compensation ramp of a coil driver
// Assumes: Register requests come from the serial slave engine on clk; pins and analog are async
// Notes: Serial protocol engine and analog stage live outside this block
//
// What this block does
// - Mode register bit picks linear or PWM output drive.
// - Linear drive enables high-side current source set by the current code.
// - PWM alternates high-side charging with low-side freewheeling each period.
// - PWM ends charging when sensed current reaches the 10-bit reference.
// - Control register picks PWM frequency from 0.5 MHz to 4 MHz.
// - Every setpoint change moves the output along a shaped ramp.
// - Ramp length tuned to 50..150 Hz resonance code at offset 07h.
// - Two-period ramp or one-period ramp variant is selectable.
// - Serial clock low for 0.5 ms forces shutdown from any state.
// - Shutdown holds while the serial clock stays low.
// - Serial clock rising in shutdown enters standby and loads defaults.
// - Standby accepts register writes with the output stage off.
// - Zero setpoint means standby; writing zero while active returns to standby.
// - Soft reset while active returns to standby with all defaults.
// - Any fault while active drops to standby and clears the setpoint.
// - Nonzero setpoint enters active; output stage stays on while active.
// - Entering active after a fault clears the status register.
// - Soft reset bit clears itself and reads back zero.
`timescale 1ns/1ps
`default_nettype none

module cdr_core
  import cdr_pkg::*;
#(
  parameter int TIMEOUT_CYC = SCL_TIMEOUT_CYC,
  parameter int SEG_SLOW = SEG_SLOW_CYC,
  parameter int SEG_FAST = SEG_FAST_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic overtemp_fault,
  input wire logic coil_short_fault,
  input wire logic coil_open_fault,
  input wire logic sense_above_ref,
  input wire cdr_req_t req,
  output logic [7:0] rdata_q,
  output cdr_pwr_t pwr_q,
  output cdr_drive_t drive_q
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [4:0] async_in;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic scl_prev_q;
  logic scl_s;
  logic [2:0] fault_s;
  logic above_s;

  assign async_in = {sense_above_ref, coil_open_fault, coil_short_fault, overtemp_fault, scl_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else if (ce)
        begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign scl_s = sync2_q[0];
  assign fault_s = sync2_q[3:1];
  assign above_s = sync2_q[4];

  always_ff @(posedge clk)
  begin
    if (!resetn)
      scl_prev_q <= 1'b0;
    else if (ce)
      scl_prev_q <= scl_s;
  end

  // ==========================================================
  // Serial clock low timeout
  // ==========================================================
  logic [19:0] low_cnt_q;
  logic scl_timeout;
  logic scl_rise;

  assign scl_timeout = (low_cnt_q == 20'(TIMEOUT_CYC));
  assign scl_rise = scl_s && !scl_prev_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      low_cnt_q <= 20'h00000;
    else if (ce)
    begin
      if (scl_s)
        low_cnt_q <= 20'h00000;
      else if (!scl_timeout)
        low_cnt_q <= low_cnt_q + 20'h00001;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  logic ring_en_q;
  logic [1:0] pwm_freq_q;
  logic [9:0] setpoint_q;
  logic [2:0] status_q;
  logic [1:0] mode_q;
  logic [7:0] res_freq_q;
  logic wr_ok;
  logic soft_reset;
  logic fault_hit;
  logic load_defaults;
  logic enter_active;

  assign wr_ok = req.wr && (pwr_q != CDR_SHUTDOWN);
  assign soft_reset = wr_ok && (req.addr == ADDR_CONTROL) && req.wdata[CTRL_SOFT_RESET_BIT];
  assign fault_hit = (pwr_q == CDR_ACTIVE) && (fault_s != 3'h0);
  assign load_defaults = (pwr_q == CDR_SHUTDOWN) || (soft_reset && !scl_timeout);
  assign enter_active = (pwr_q == CDR_STANDBY) && (setpoint_q != 10'h000) && !scl_timeout;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ring_en_q <= RING_EN_RST;
      pwm_freq_q <= PWM_FREQ_RST;
      mode_q <= MODE_RST;
      res_freq_q <= RES_FREQ_RST;
    end
    else if (ce)
    begin
      if (load_defaults)
      begin
        ring_en_q <= RING_EN_RST;
        pwm_freq_q <= PWM_FREQ_RST;
        mode_q <= MODE_RST;
        res_freq_q <= RES_FREQ_RST;
      end
      else if (wr_ok)
      begin
        case (req.addr)
          ADDR_CONTROL:
          begin
            ring_en_q <= req.wdata[CTRL_RING_EN_BIT];
            pwm_freq_q <= req.wdata[CTRL_PWM_FREQ_LSB +: 2];
          end
          ADDR_MODE: mode_q <= req.wdata[1:0];
          ADDR_RES_FREQ: res_freq_q <= req.wdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      setpoint_q <= SETPOINT_RST;
    else if (ce)
    begin
      if (load_defaults)
        setpoint_q <= SETPOINT_RST;
      else if (fault_hit)
        setpoint_q <= SETPOINT_RST;
      else if (wr_ok && req.addr == ADDR_SETPOINT_MSB)
        setpoint_q[9:8] <= req.wdata[1:0];
      else if (wr_ok && req.addr == ADDR_SETPOINT_LSB)
        setpoint_q[7:0] <= req.wdata;
    end
  end

  // Sticky fault flags, captured while active
  always_ff @(posedge clk)
  begin
    if (!resetn)
      status_q <= STATUS_RST;
    else if (ce)
    begin
      if (load_defaults)
        status_q <= STATUS_RST;
      else if (enter_active)
        status_q <= STATUS_RST;
      else if (pwr_q == CDR_ACTIVE)
        status_q <= status_q | fault_s;
    end
  end

  // Soft reset bit is never stored, so it reads as zero
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else if (ce && req.rd)
    begin
      case (req.addr)
        ADDR_CONTROL: rdata_q <= {4'h0, pwm_freq_q, ring_en_q, 1'b0};
        ADDR_SETPOINT_MSB: rdata_q <= {6'h00, setpoint_q[9:8]};
        ADDR_SETPOINT_LSB: rdata_q <= setpoint_q[7:0];
        ADDR_STATUS: rdata_q <= {5'h00, status_q};
        ADDR_MODE: rdata_q <= {6'h00, mode_q};
        ADDR_RES_FREQ: rdata_q <= res_freq_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Power mode state machine
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (!resetn)
      pwr_q <= CDR_STANDBY;
    else if (ce)
    begin
      case (pwr_q)
        CDR_SHUTDOWN:
        begin
          if (scl_rise)
            pwr_q <= CDR_STANDBY;
        end
        CDR_STANDBY:
        begin
          if (scl_timeout)
            pwr_q <= CDR_SHUTDOWN;
          else if (enter_active)
            pwr_q <= CDR_ACTIVE;
        end
        CDR_ACTIVE:
        begin
          if (scl_timeout)
            pwr_q <= CDR_SHUTDOWN;
          else if (soft_reset || fault_hit)
            pwr_q <= CDR_STANDBY;
          else if (setpoint_q == 10'h000)
            pwr_q <= CDR_STANDBY;
        end
        default: pwr_q <= CDR_STANDBY;
      endcase
    end
  end

  // ==========================================================
  // Ringing compensation ramp
  // ==========================================================
  logic active;
  logic [9:0] level_q;
  logic [9:0] tgt_q;
  logic [9:0] start_q;
  logic [3:0] seg_q;
  logic [19:0] seg_cnt_q;
  logic [19:0] seg_len_q;
  logic busy_q;
  logic [31:0] seg_len_one;
  logic [19:0] seg_len_new;
  logic signed [10:0] delta;
  logic signed [21:0] scaled;
  logic signed [21:0] next_level;
  logic [3:0] seg_next;

  assign active = (pwr_q == CDR_ACTIVE);
  assign seg_len_one = 32'(SEG_SLOW) - (32'(res_freq_q) * 32'(SEG_SLOW - SEG_FAST)) / 32'd255;
  assign seg_len_new = mode_q[MODE_TWO_PERIOD_BIT] ? 20'(seg_len_one << 1) : 20'(seg_len_one);
  assign delta = $signed({1'b0, tgt_q}) - $signed({1'b0, start_q});
  assign seg_next = seg_q + 4'h1;
  assign scaled = 22'(delta * $signed({1'b0, RAMP_W[seg_next]}));
  assign next_level = $signed({12'h000, start_q}) + (scaled >>> 8);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      level_q <= 10'h000;
      tgt_q <= 10'h000;
      start_q <= 10'h000;
      seg_q <= 4'h0;
      seg_cnt_q <= 20'h00000;
      seg_len_q <= 20'h00001;
      busy_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!active)
      begin
        level_q <= 10'h000;
        tgt_q <= 10'h000;
        busy_q <= 1'b0;
      end
      else if (setpoint_q != tgt_q)
      begin
        tgt_q <= setpoint_q;
        start_q <= level_q;
        seg_cnt_q <= 20'h00000;
        seg_q <= 4'hf;
        seg_len_q <= seg_len_new;
        busy_q <= ring_en_q;
        if (!ring_en_q)
          level_q <= setpoint_q;
      end
      else if (busy_q)
      begin
        if (seg_cnt_q + 20'h00001 >= seg_len_q)
        begin
          seg_cnt_q <= 20'h00000;
          seg_q <= seg_next;
          level_q <= 10'(next_level);
          if (seg_next == 4'hf)
            busy_q <= 1'b0;
        end
        else
          seg_cnt_q <= seg_cnt_q + 20'h00001;
      end
    end
  end

  // ==========================================================
  // Output stage control
  // ==========================================================
  logic [6:0] pwm_cnt_q;
  logic [6:0] pwm_per;
  logic pwm_mode;

  assign pwm_mode = mode_q[MODE_PWM_BIT];

  always_comb
  begin
    case (pwm_freq_q)
      2'h0: pwm_per = PWM_P0_CYC;
      2'h1: pwm_per = PWM_P1_CYC;
      2'h2: pwm_per = PWM_P2_CYC;
      default: pwm_per = PWM_P3_CYC;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      pwm_cnt_q <= 7'h00;
    else if (ce)
    begin
      if (!active || !pwm_mode || pwm_cnt_q + 7'h01 >= pwm_per)
        pwm_cnt_q <= 7'h00;
      else
        pwm_cnt_q <= pwm_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      drive_q <= '0;
    else if (ce)
    begin
      drive_q.stage_en <= active;
      drive_q.pwm_sel <= pwm_mode;
      drive_q.lin_src_en <= active && !pwm_mode;
      drive_q.dac_code <= level_q;
      if (!active || !pwm_mode)
      begin
        drive_q.hs_on <= 1'b0;
        drive_q.ls_on <= 1'b0;
      end
      else if (pwm_cnt_q == 7'h00 && !above_s)
      begin
        drive_q.hs_on <= 1'b1;
        drive_q.ls_on <= 1'b0;
      end
      else if (above_s || pwm_cnt_q == 7'h00)
      begin
        drive_q.hs_on <= 1'b0;
        drive_q.ls_on <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ### verif/cdr_sva.sv
// Purpose: Port assertions for the coil driver core
// Assumes: One clk domain, synchronous active-low reset, ce held high
// Notes: Bound into every cdr_core instance
`timescale 1ns/1ps
`default_nettype none
module cdr_sva
  import cdr_pkg::*;
#(
  parameter int TIMEOUT_CYC = SCL_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic overtemp_fault,
  input wire logic coil_short_fault,
  input wire logic coil_open_fault,
  input wire logic sense_above_ref,
  input wire cdr_req_t req,
  input wire logic [7:0] rdata_q,
  input wire cdr_pwr_t pwr_q,
  input wire cdr_drive_t drive_q
);
  // ==========
  // Helpers
  // ==========
  logic [15:0] low_cnt_q;
  logic any_fault;
  assign any_fault = overtemp_fault || coil_short_fault || coil_open_fault;
  always_ff @(posedge clk)
  begin
    if (!resetn || scl_pin)
      low_cnt_q <= '0;
    else if (ce && low_cnt_q != 16'hffff)
      low_cnt_q <= low_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========
  // Properties
  // ==========
  property p_excl; !(drive_q.hs_on && drive_q.ls_on); endproperty
  a_excl: assert property (p_excl) else $error("both switches on");
  property p_stage; drive_q.stage_en == ($past(pwr_q) == CDR_ACTIVE); endproperty
  a_stage: assert property (p_stage) else $error("stage enable off track");
  property p_idle; !drive_q.stage_en |-> !drive_q.lin_src_en && !drive_q.hs_on; endproperty
  a_idle: assert property (p_idle) else $error("drive while stage off");
  property p_lin; !drive_q.pwm_sel |-> !drive_q.hs_on && !drive_q.ls_on; endproperty
  a_lin: assert property (p_lin) else $error("switching in linear drive");
  property p_shut;
    pwr_q == CDR_SHUTDOWN && !scl_pin && !$past(scl_pin) && !$past(scl_pin, 2)
      && !$past(scl_pin, 3) |=> pwr_q == CDR_SHUTDOWN;
  endproperty
  a_shut: assert property (p_shut) else $error("left shutdown with clock low");
  property p_tmo; low_cnt_q == 16'(TIMEOUT_CYC + 4) |-> pwr_q == CDR_SHUTDOWN; endproperty
  a_tmo: assert property (p_tmo) else $error("no shutdown on clock low");
  property p_sr; req.rd && req.addr == ADDR_CONTROL |=> !rdata_q[0]; endproperty
  a_sr: assert property (p_sr) else $error("soft reset bit reads one");
  property p_flt; pwr_q == CDR_ACTIVE && any_fault |-> ##[1:4] pwr_q == CDR_STANDBY; endproperty
  a_flt: assert property (p_flt) else $error("fault kept active");
  property p_enter;
    pwr_q == CDR_STANDBY && req.wr && req.addr == ADDR_SETPOINT_LSB && req.wdata != 8'h00
      && scl_pin && !any_fault |=> ##1 pwr_q == CDR_ACTIVE;
  endproperty
  a_enter: assert property (p_enter) else $error("nonzero setpoint not active");
endmodule
bind cdr_core cdr_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (.clk(clk), .resetn(resetn), .ce(ce),
  .scl_pin(scl_pin), .overtemp_fault(overtemp_fault), .coil_short_fault(coil_short_fault),
  .coil_open_fault(coil_open_fault), .sense_above_ref(sense_above_ref), .req(req),
  .rdata_q(rdata_q), .pwr_q(pwr_q), .drive_q(drive_q));
`default_nettype wire

// ### verif/cdr_partner.sv
// Purpose: Serial host model issuing register requests
// Assumes: Link clock made from clk, 8 cycles per bit
// Notes: Clock idles high on its pull-up between frames
`timescale 1ns/1ps
`default_nettype none
module cdr_partner
  import cdr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire cdr_req_t cmd,
  input wire logic hold_low,
  output cdr_req_t req,
  output logic scl_pin,
  output logic busy
);
  logic [5:0] cnt_q;
  cdr_req_t cmd_q;
  always_ff @(posedge clk)
  begin
    req <= '0;
    if (!resetn)
    begin
      busy <= 1'b0;
      cnt_q <= '0;
    end
    else if (go && !busy)
    begin
      busy <= 1'b1;
      cnt_q <= '0;
      cmd_q <= cmd;
    end
    else if (busy)
    begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q == 6'h3f)
      begin
        busy <= 1'b0;
        req <= cmd_q;
      end
    end
  end
  // Frame toggles the clock; holding low requests shutdown
  assign scl_pin = !hold_low && (!busy || !cnt_q[2]);
endmodule
`default_nettype wire

// ### verif/tb_coil_driver_mode_and_ringing_control.sv
// Purpose: Self-checking bench for the coil driver core
// Assumes: Short counts set by parameters, ce held high except for two 50-cycle drops that check the ramp output holds
// Notes: Register model in integers, host model drives the port
`timescale 1ns/1ps
`default_nettype none
module tb_coil_driver_mode_and_ringing_control
  import cdr_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, go = 1'b0, hold_low = 1'b0, sense = 1'b0, ce = 1'b1;
  logic [2:0] flt = 3'h0;
  cdr_req_t cmd = '0, req;
  logic scl_pin, busy;
  logic [7:0] rdata_q;
  cdr_pwr_t pwr_q;
  cdr_drive_t drive_q;
  int mismatches = 0, cmp_count = 0, cyc = 0, per, pwr_m;
  int m[8];
  logic [31:0] seed = 32'h743889d5;
  always #10 clk = ~clk;
  cdr_core #(.TIMEOUT_CYC(20), .SEG_SLOW(40), .SEG_FAST(10)) dut_u (.clk(clk),
    .resetn(resetn), .ce(ce), .scl_pin(scl_pin), .overtemp_fault(flt[0]),
    .coil_short_fault(flt[1]), .coil_open_fault(flt[2]), .sense_above_ref(sense),
    .req(req), .rdata_q(rdata_q), .pwr_q(pwr_q), .drive_q(drive_q));
  cdr_partner u_host (.clk(clk), .resetn(resetn), .go(go), .cmd(cmd),
    .hold_low(hold_low), .req(req), .scl_pin(scl_pin), .busy(busy));
  // Comparator trips one cycle into charging
  always @(posedge clk) sense <= drive_q.hs_on;
  // ==========
  // Helpers
  // ==========
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task give_verdict();
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task op(input logic w, input int a, input int d);
    int i;
    go <= 1'b1;
    cmd <= '{wr: w, rd: !w, addr: 8'(a), wdata: 8'(d)};
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 80 && (i < 2 || busy); i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task wr(input int a, input int d);
    op(1'b1, a, d);
    if (a == 2 && d % 2 == 1)
    begin
      m = '{0, 0, 2, 0, 0, 0, 0, 131};
      pwr_m = 1;
    end
    else if (a == 2 || a == 3 || a == 6)
      m[a] = d & (a == 2 ? 14 : 3);
    else if (a == 4 || a == 7)
      m[a] = d;
    if (a == 3 || a == 4)
      pwr_m = (m[3] | m[4]) != 0 ? 2 : 1;
    if (pwr_m == 2)
      m[5] = 0;
  endtask
  task rd(input int a);
    op(1'b0, a, 0);
    chk(rdata_q, a < 8 ? m[a] : 0);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  // ==========
  // Scenarios
  // ==========
  initial
  begin
    int f, v, tgt;
    time t0;
    int pers[4] = '{100, 50, 25, 12};
    m = '{0, 0, 2, 0, 0, 0, 0, 131};
    pwr_m = 1;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (f = 0; f < 9; f++) rd(f);
    wr(7, 255);
    rd(7);
    for (v = 0; v < 2; v++)
    begin
      tgt = 128 + rnd() % 128;
      wr(6, v * 2);
      wr(4, tgt);
      chk(pwr_q, pwr_m);
      chk({drive_q.stage_en, drive_q.lin_src_en, drive_q.pwm_sel}, 3'b110);
      repeat (190) @(posedge clk);
      chk(drive_q.dac_code == tgt, v == 0);
      ce <= 1'b0;
      @(posedge clk);
      per = drive_q.dac_code;
      repeat (50) @(posedge clk);
      chk(drive_q.dac_code, per);
      ce <= 1'b1;
      if (v == 1)
        wr(7, 0);
      repeat (200) @(posedge clk);
      chk(drive_q.dac_code, tgt);
      wr(4, 0);
      chk(pwr_q, pwr_m);
      chk(drive_q.stage_en, 0);
    end
    wr(4, 1 + rnd() % 255);
    wr(6, 1);
    chk(drive_q.pwm_sel, 1);
    for (f = 0; f < 4; f++)
    begin
      wr(2, f * 4 + 2);
      repeat (2) @(posedge drive_q.hs_on);
      t0 = $time;
      @(posedge drive_q.hs_on);
      per = ($time - t0) / 20;
      chk(per, pers[f]);
      repeat (8) @(posedge clk);
      chk({drive_q.hs_on, drive_q.ls_on}, 2'b01);
    end
    for (f = 0; f < 3; f++)
    begin
      flt <= 3'(1 << f);
      repeat (8) @(posedge clk);
      chk(pwr_q, CDR_STANDBY);
      flt <= 3'h0;
      m[4] = 0;
      m[5] = 1 << f;
      pwr_m = 1;
      rd(4);
      rd(5);
      wr(4, 1 + rnd() % 255);
      rd(5);
    end
    wr(2, 3);
    chk(pwr_q, pwr_m);
    rd(2);
    rd(7);
    wr(4, 16);
    hold_low <= 1'b1;
    repeat (30) @(posedge clk);
    chk(pwr_q, CDR_SHUTDOWN);
    repeat (40) @(posedge clk);
    chk(pwr_q, CDR_SHUTDOWN);
    hold_low <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pwr_q, CDR_STANDBY);
    m = '{0, 0, 2, 0, 0, 0, 0, 131};
    pwr_m = 1;
    for (f = 2; f < 8; f++) rd(f);
    give_verdict();
  end
endmodule
`default_nettype wire
